// *** pkg/viu_cfg.svh ***
// Offsets, field positions and reset values of the vectored interrupt unit
`ifndef VIU_CFG_SVH
`define VIU_CFG_SVH
`define VIU_NCH        32
`define VIU_PRIO_W     4
`define VIU_EXT3_CH    5'h11
`define VIU_ADR_W      12
`define VIU_PG_CTRL    4'h0
`define VIU_PG_VECT    4'h1
`define VIU_PG_PRIO    4'h2
`define VIU_OFF_CLASS  8'h00
`define VIU_OFF_ENABLE 8'h04
`define VIU_OFF_RAW    8'h08
`define VIU_OFF_FAST   8'h0C
`define VIU_OFF_NORM   8'h10
`define VIU_OFF_VADDR  8'h14
`define VIU_OFF_RISE0  8'h18
`define VIU_OFF_FALL0  8'h1C
`define VIU_OFF_RISE2  8'h20
`define VIU_OFF_FALL2  8'h24
`define VIU_OFF_EDGE0  8'h28
`define VIU_OFF_EDGE2  8'h2C
`define VIU_OFF_MASK0  8'h30
`define VIU_OFF_MASK2  8'h34
`define VIU_RST_WORD   32'h0000_0000
`define VIU_RST_PRIO   4'h0
`define VIU_WARM_CYC   2'h3
`endif

// *** pkg/viu_pkg.sv ***
// Types of the vectored interrupt unit
`include "viu_cfg.svh"
package viu_pkg;
   typedef struct packed {
      logic                    cyc;
      logic                    stb;
      logic                    we;
      logic [`VIU_ADR_W-1:0]   adr;
      logic [3:0]              sel;
      logic [31:0]             dat;
   } viu_wb_req_s;
   typedef struct packed {
      logic                    ack;
      logic [31:0]             dat;
   } viu_wb_rsp_s;
   typedef struct packed {
      logic [31:0]                             fast_sel;
      logic [31:0]                             enable;
      logic [`VIU_NCH-1:0][31:0]               vect;
      logic [`VIU_NCH-1:0][`VIU_PRIO_W-1:0]    prio;
      logic [1:0][31:0]                        rise_en;
      logic [1:0][31:0]                        fall_en;
      logic [1:0][31:0]                        mask;
      logic [31:0]                             vect_addr;
      logic                                    ack;
      logic [31:0]                             rdat;
   } viu_state_s;
   typedef struct packed {
      logic [63:0]             sync1;
      logic [63:0]             sync2;
      logic [63:0]             prev;
      logic [63:0]             flag;
      logic [1:0]              warm;
   } viu_edge_state_s;
endpackage

// *** rtl/viu_edge_detect.sv ***
// Pin edge detector with sticky flags for the two gpio ports
`timescale 1ns/1ps
module viu_edge_detect
   import viu_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [63:0] pins_i,
   input  wire logic [63:0] rise_en_i,
   input  wire logic [63:0] fall_en_i,
   input  wire logic [63:0] clr_i,
   output logic      [63:0] flag_o
);
   viu_edge_state_s s_reg;
   viu_edge_state_s s_next;
   logic [63:0]     rise;
   logic [63:0]     fall;

   always_comb
   begin
      s_next = s_reg;
      s_next.sync1 = pins_i;
      s_next.sync2 = s_reg.sync1;
      s_next.prev = s_reg.sync2;
      if (s_reg.warm != `VIU_WARM_CYC)
      begin
         s_next.warm = s_reg.warm + 2'h1;
      end
      // Edges ignored until the pipeline holds real pin levels
      rise = (s_reg.warm == `VIU_WARM_CYC) ? (s_reg.sync2 & ~s_reg.prev) : 64'h0;
      fall = (s_reg.warm == `VIU_WARM_CYC) ? (~s_reg.sync2 & s_reg.prev) : 64'h0;
      // Set wins over clear
      s_next.flag = (s_reg.flag & ~clr_i) | (rise & rise_en_i) | (fall & fall_en_i);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign flag_o = s_reg.flag;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_edge_rise_flag: assert property (
      (s_reg.warm == `VIU_WARM_CYC) && (|(s_reg.sync2 & ~s_reg.prev & rise_en_i))
      |=> |(flag_o & $past(s_reg.sync2 & ~s_reg.prev & rise_en_i)))
      else $error("Enabled rising edge did not set its flag");
   a_edge_fall_flag: assert property (
      (s_reg.warm == `VIU_WARM_CYC) && (|(~s_reg.sync2 & s_reg.prev & fall_en_i))
      |=> |(flag_o & $past(~s_reg.sync2 & s_reg.prev & fall_en_i)))
      else $error("Enabled falling edge did not set its flag");
endmodule

// *** rtl/viu_vector_irq_unit.sv ***
// Vectored interrupt unit with fast class, priorities and gpio edge merge
//
// Summary of operation
// - 32 inputs, each software-classed fast or vectored
// - Fast class takes precedence over vectored class
// - Fast output ORs active fast-class requests
// - Readable word shows requesting fast sources
// - Non-fast inputs are vectored with programmable priority
// - Equal priority ties pick lowest channel
// - Normal output ORs active vectored requests
// - Readable register gives selected handler address
// - 64 port pins raise rising/falling/both edge interrupts
// - Port edge requests merge onto external line three
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ps
module viu_vector_irq_unit
   import viu_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  viu_wb_req_s      wb_i,
   output viu_wb_rsp_s      wb_o,
   input  wire logic [31:0] irq_req_i,
   input  wire logic [31:0] gpio_port_first_i,
   input  wire logic [31:0] gpio_port_third_i,
   output logic             fast_irq_line_o,
   output logic             norm_irq_o,
   output logic             gpio_irq_o
);
   viu_state_s                 s_reg;
   viu_state_s                 s_next;
   logic [63:0]                edge_flag;
   logic [63:0]                edge_clr;
   logic [31:0]                line;
   logic [31:0]                act;
   logic [31:0]                fast_act;
   logic [31:0]                norm_act;
   logic                       gpio_pend;
   logic [31:0]                rd_word;
   logic [31:0]                wones;
   logic                       req;
   logic                       wr;
   logic [3:0]                 page;
   logic [7:0]                 off;
   logic [4:0]                 idx;
   logic [`VIU_PRIO_W-1:0]     best_p;
   logic [4:0]                 best_i;
   logic                       any_v;
   logic [31:0]                sel_vec;
   logic                       bad_sel;

   function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old_w;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            r[b*8 +: 8] = new_w[b*8 +: 8];
         end
      end
      return r;
   endfunction

   viu_edge_detect u_edge (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .pins_i    ({gpio_port_third_i, gpio_port_first_i}),
      .rise_en_i ({s_reg.rise_en[1], s_reg.rise_en[0]}),
      .fall_en_i ({s_reg.fall_en[1], s_reg.fall_en[0]}),
      .clr_i     (edge_clr),
      .flag_o    (edge_flag)
   );

   // Request gathering
   always_comb
   begin
      gpio_pend = |(edge_flag & {s_reg.mask[1], s_reg.mask[0]});
      line = irq_req_i;
      line[`VIU_EXT3_CH] = irq_req_i[`VIU_EXT3_CH] | gpio_pend;
      act = line & s_reg.enable;
      fast_act = act & s_reg.fast_sel;
      norm_act = act & ~s_reg.fast_sel;
   end

   assign fast_irq_line_o = |fast_act;
   assign norm_irq_o = |norm_act;
   assign gpio_irq_o = gpio_pend;

   // Vectored arbitration, fast-class channels never compete here
   always_comb
   begin
      best_p = `VIU_RST_PRIO;
      best_i = 5'h00;
      any_v = 1'b0;
      for (int i = `VIU_NCH - 1; i >= 0; i--)
      begin
         if (norm_act[i] && (!any_v || s_reg.prio[i] >= best_p))
         begin
            best_p = s_reg.prio[i];
            best_i = 5'(i);
            any_v = 1'b1;
         end
      end
      sel_vec = s_reg.vect[best_i];
   end

   // Bus decode
   always_comb
   begin
      req = wb_i.cyc & wb_i.stb;
      wr = req & wb_i.we & s_reg.ack;
      page = wb_i.adr[11:8];
      off = wb_i.adr[7:0];
      idx = wb_i.adr[6:2];
      wones = merge(32'h0000_0000, wb_i.dat, wb_i.sel);
      rd_word = 32'h0000_0000;
      case (page)
         `VIU_PG_CTRL:
         begin
            case (off)
               `VIU_OFF_CLASS:  rd_word = s_reg.fast_sel;
               `VIU_OFF_ENABLE: rd_word = s_reg.enable;
               `VIU_OFF_RAW:    rd_word = line;
               `VIU_OFF_FAST:   rd_word = fast_act;
               `VIU_OFF_NORM:   rd_word = norm_act;
               `VIU_OFF_VADDR:  rd_word = s_reg.vect_addr;
               `VIU_OFF_RISE0:  rd_word = s_reg.rise_en[0];
               `VIU_OFF_FALL0:  rd_word = s_reg.fall_en[0];
               `VIU_OFF_RISE2:  rd_word = s_reg.rise_en[1];
               `VIU_OFF_FALL2:  rd_word = s_reg.fall_en[1];
               `VIU_OFF_EDGE0:  rd_word = edge_flag[31:0];
               `VIU_OFF_EDGE2:  rd_word = edge_flag[63:32];
               `VIU_OFF_MASK0:  rd_word = s_reg.mask[0];
               `VIU_OFF_MASK2:  rd_word = s_reg.mask[1];
               default:         rd_word = 32'h0000_0000;
            endcase
         end
         `VIU_PG_VECT:
         begin
            if (!wb_i.adr[7])
            begin
               rd_word = s_reg.vect[idx];
            end
         end
         `VIU_PG_PRIO:
         begin
            if (!wb_i.adr[7])
            begin
               rd_word = {28'h0000000, s_reg.prio[idx]};
            end
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // Next state
   always_comb
   begin
      s_next = s_reg;
      edge_clr = 64'h0;
      s_next.ack = req & ~s_reg.ack;
      if (req & ~s_reg.ack)
      begin
         s_next.rdat = rd_word;
      end
      if (wr && page == `VIU_PG_CTRL)
      begin
         case (off)
            `VIU_OFF_CLASS:  s_next.fast_sel = merge(s_reg.fast_sel, wb_i.dat, wb_i.sel);
            `VIU_OFF_ENABLE: s_next.enable = merge(s_reg.enable, wb_i.dat, wb_i.sel);
            `VIU_OFF_RISE0:  s_next.rise_en[0] = merge(s_reg.rise_en[0], wb_i.dat, wb_i.sel);
            `VIU_OFF_FALL0:  s_next.fall_en[0] = merge(s_reg.fall_en[0], wb_i.dat, wb_i.sel);
            `VIU_OFF_RISE2:  s_next.rise_en[1] = merge(s_reg.rise_en[1], wb_i.dat, wb_i.sel);
            `VIU_OFF_FALL2:  s_next.fall_en[1] = merge(s_reg.fall_en[1], wb_i.dat, wb_i.sel);
            `VIU_OFF_EDGE0:  edge_clr[31:0] = wones;
            `VIU_OFF_EDGE2:  edge_clr[63:32] = wones;
            `VIU_OFF_MASK0:  s_next.mask[0] = merge(s_reg.mask[0], wb_i.dat, wb_i.sel);
            `VIU_OFF_MASK2:  s_next.mask[1] = merge(s_reg.mask[1], wb_i.dat, wb_i.sel);
            default:         ;
         endcase
      end
      if (wr && page == `VIU_PG_VECT && !wb_i.adr[7])
      begin
         s_next.vect[idx] = merge(s_reg.vect[idx], wb_i.dat, wb_i.sel);
      end
      if (wr && page == `VIU_PG_PRIO && !wb_i.adr[7] && wb_i.sel[0])
      begin
         s_next.prio[idx] = wb_i.dat[`VIU_PRIO_W-1:0];
      end
      s_next.vect_addr = any_v ? sel_vec : `VIU_RST_WORD;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign wb_o.ack = s_reg.ack;
   assign wb_o.dat = s_reg.rdat;

   // Checking helper
   always_comb
   begin
      bad_sel = 1'b0;
      for (int j = 0; j < `VIU_NCH; j++)
      begin
         if (norm_act[j] && (s_reg.prio[j] > best_p || (s_reg.prio[j] == best_p && 5'(j) < best_i)))
         begin
            bad_sel = 1'b1;
         end
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_class_write: assert property (
      (wr && page == `VIU_PG_CTRL && off == `VIU_OFF_CLASS && wb_i.sel == 4'hF)
      |=> s_reg.fast_sel == $past(wb_i.dat))
      else $error("Class write not stored");
   a_fast_over_norm: assert property (
      any_v |-> !s_reg.fast_sel[best_i])
      else $error("Fast channel entered vectored arbitration");
   a_fast_or: assert property (
      fast_irq_line_o == |(line & s_reg.enable & s_reg.fast_sel))
      else $error("Fast output differs from OR of fast requests");
   a_fast_word: assert property (
      (req && !s_reg.ack && !wb_i.we && page == `VIU_PG_CTRL && off == `VIU_OFF_FAST)
      |=> wb_o.ack && wb_o.dat == $past(fast_act))
      else $error("Fast status word wrong");
   a_prio_write: assert property (
      (wr && page == `VIU_PG_PRIO && !wb_i.adr[7] && wb_i.sel[0])
      |=> s_reg.prio[$past(idx)] == $past(wb_i.dat[3:0]))
      else $error("Priority write not stored");
   a_pick_best: assert property (
      any_v |-> !bad_sel)
      else $error("Selected channel not highest or not lowest on tie");
   a_norm_or: assert property (
      norm_irq_o == |(act & ~s_reg.fast_sel))
      else $error("Normal output differs from OR of vectored requests");
   a_vect_follow: assert property (
      any_v |=> s_reg.vect_addr == $past(sel_vec))
      else $error("Vector address does not follow selection");
   a_vect_idle: assert property (
      !any_v ##1 !any_v |-> s_reg.vect_addr == `VIU_RST_WORD)
      else $error("Vector address not cleared when idle");
   a_ext3_merge: assert property (
      gpio_pend |-> line[`VIU_EXT3_CH])
      else $error("Port edge request missing on line three");
   a_ack_drop: assert property (
      wb_o.ack |=> !wb_o.ack)
      else $error("Ack held two cycles");

   a_read_ack: assert property (
      (req && !s_reg.ack) |=> wb_o.ack)
      else $error("Request not answered in one cycle");
   a_unmapped_zero: assert property (
      (req && !s_reg.ack && !wb_i.we && page == 4'h3) |=> wb_o.dat == 32'h0000_0000)
      else $error("Unmapped read not zero");
   a_enable_write: assert property (
      (wr && page == `VIU_PG_CTRL && off == `VIU_OFF_ENABLE && wb_i.sel == 4'hF)
      |=> s_reg.enable == $past(wb_i.dat))
      else $error("Enable write not stored");
   a_vect_write: assert property (
      (wr && page == `VIU_PG_VECT && !wb_i.adr[7] && wb_i.sel == 4'hF)
      |=> s_reg.vect[$past(idx)] == $past(wb_i.dat))
      else $error("Vector write not stored");
   a_vect_read: assert property (
      (req && !s_reg.ack && !wb_i.we && page == `VIU_PG_CTRL && off == `VIU_OFF_VADDR)
      |=> wb_o.dat == $past(s_reg.vect_addr))
      else $error("Vector address read wrong");

   a_disabled_quiet: assert property (
      (s_reg.enable == 32'h0000_0000) |-> !fast_irq_line_o && !norm_irq_o)
      else $error("Output raised with all channels disabled");
   a_fast_class_only: assert property (
      fast_irq_line_o |-> |(s_reg.fast_sel & s_reg.enable))
      else $error("Fast output without an enabled fast channel");
   a_prio_hold: assert property (
      !(wr && page == `VIU_PG_PRIO) |=> $stable(s_reg.prio))
      else $error("Priority changed without a write");
   a_sel_active: assert property (
      any_v |-> norm_act[best_i])
      else $error("Selected channel not an active vectored request");
   a_ext3_norm: assert property (
      (gpio_irq_o && s_reg.enable[`VIU_EXT3_CH] && !s_reg.fast_sel[`VIU_EXT3_CH]) |-> norm_irq_o)
      else $error("Port edge request did not raise normal output");

   c_fast_irq: cover property (fast_irq_line_o);
   c_norm_tie: cover property (any_v && $countones(norm_act) > 1);
   c_gpio_irq: cover property (gpio_irq_o ##1 norm_irq_o);
   c_prio_write: cover property (wr && page == `VIU_PG_PRIO && any_v);
   c_fast_norm: cover property (fast_irq_line_o && norm_irq_o);
endmodule

// *** bench/viu_periph_model.sv ***
// Peripheral side model: each peripheral merges two flags onto its one line
`timescale 1ns/1ps
module viu_periph_model
(
   input  wire logic        clk_i,
   input  wire logic [63:0] flags_i,
   output logic      [31:0] irq_o
);
   initial irq_o = '0;
   always @(posedge clk_i)
   begin
      for (int n = 0; n < 32; n++)
         irq_o[n] <= flags_i[2*n] | flags_i[2*n+1];
   end
endmodule

// *** bench/viu_vector_irq_unit_bench.sv ***
// Self-checking bench of the vectored interrupt unit
`timescale 1ns/1ps
`include "viu_cfg.svh"
module viu_vector_irq_unit_bench
   import viu_pkg::*;
;
   logic            clk_i = 1'b0;
   logic            rst_i = 1'b1;
   viu_wb_req_s     wb_req = '0;
   viu_wb_rsp_s     wb_rsp;
   logic     [63:0] flags = '0;
   logic     [31:0] irq_req;
   logic     [31:0] pin0 = '0;
   logic     [31:0] pin2 = '0;
   logic            fast_o;
   logic            norm_o;
   logic            gpio_o;
   logic     [31:0] seed = 32'hCC5499EA;
   logic     [31:0] vt [8];
   logic     [31:0] exp_q [$];
   int              fail_count = 0;
   int              checks_done = 0;

   always #10 clk_i = ~clk_i;

   viu_periph_model i_per (.clk_i(clk_i), .flags_i(flags), .irq_o(irq_req));

   viu_vector_irq_unit i_dut
   (
      .clk_i             (clk_i),
      .rst_i             (rst_i),
      .wb_i              (wb_req),
      .wb_o              (wb_rsp),
      .irq_req_i         (irq_req),
      .gpio_port_first_i (pin0),
      .gpio_port_third_i (pin2),
      .fast_irq_line_o   (fast_o),
      .norm_irq_o        (norm_o),
      .gpio_irq_o        (gpio_o)
   );

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   function automatic logic [11:0] ra(input logic [7:0] off);
      return {`VIU_PG_CTRL, off};
   endfunction

   task automatic test_done();
      if (exp_q.size() != 0)
      begin
         fail_count++;
         $display("[ERR] pending reads expected 0 seen %0d", exp_q.size());
      end
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk_i);
         if (wb_rsp.ack === 1'b1)
            break;
      end
      wb_req.cyc <= 1'b0;
      wb_req.stb <= 1'b0;
      if (i == 20)
      begin
         fail_count++;
         test_done();
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   task automatic waitg();
      int i;
      for (i = 0; i < 10 && gpio_o !== 1'b1; i++)
         @(negedge clk_i);
      if (gpio_o !== 1'b1)
      begin
         fail_count++;
         test_done();
      end
   endtask

   // Read monitor: oldest expectation against each read answer
   always @(posedge clk_i)
   begin
      if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0 && exp_q.size() > 0)
         check("read data", wb_rsp.dat, exp_q.pop_front());
   end

   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ra(`VIU_OFF_CLASS), `VIU_RST_WORD);
      rd(ra(`VIU_OFF_VADDR), 32'h0);
      rd(12'h3FC, 32'h0);
      wr(ra(`VIU_OFF_ENABLE), 32'hFFFFFFFF);
      for (int n = 0; n < 8; n++)
      begin
         seed = xs(seed);
         vt[n] = seed;
         wr({`VIU_PG_VECT, 8'(4 * n)}, seed);
      end
      $display("test reset done");
      wr(ra(`VIU_OFF_CLASS), 32'h1);
      flags <= 64'h6;
      settle(3);
      check("fast line", fast_o, 32'h1);
      check("normal line", norm_o, 32'h1);
      rd(ra(`VIU_OFF_FAST), 32'h1);
      rd(ra(`VIU_OFF_NORM), 32'h2);
      rd(ra(`VIU_OFF_VADDR), vt[1]);
      flags <= 64'h2;
      settle(3);
      check("normal line", norm_o, 32'h0);
      rd(ra(`VIU_OFF_VADDR), 32'h0);
      wr(ra(`VIU_OFF_CLASS), 32'h0);
      flags <= 64'h6;
      settle(3);
      check("fast line", fast_o, 32'h0);
      rd(ra(`VIU_OFF_VADDR), vt[0]);
      $display("test fast class done");
      flags <= 64'h2100;
      settle(3);
      rd(ra(`VIU_OFF_VADDR), vt[4]);
      wr({`VIU_PG_PRIO, 8'h18}, 32'h5);
      rd(ra(`VIU_OFF_VADDR), vt[6]);
      wr({`VIU_PG_PRIO, 8'h10}, 32'hF);
      rd(ra(`VIU_OFF_VADDR), vt[4]);
      wr(ra(`VIU_OFF_ENABLE), 32'hFFFFFFEF);
      rd(ra(`VIU_OFF_VADDR), vt[6]);
      wr(ra(`VIU_OFF_ENABLE), 32'hFFFFFFFF);
      flags <= 64'h0;
      $display("test priority done");
      wr(ra(`VIU_OFF_RISE0), 32'h4);
      wr(ra(`VIU_OFF_MASK0), 32'h4);
      wr(ra(`VIU_OFF_FALL2), 32'h2);
      wr(ra(`VIU_OFF_MASK2), 32'h2);
      pin0[2] <= 1'b1;
      waitg();
      check("normal line", norm_o, 32'h1);
      rd(ra(`VIU_OFF_RAW), 32'h0002_0000);
      rd(ra(`VIU_OFF_EDGE0), 32'h4);
      wr(ra(`VIU_OFF_MASK0), 32'h0);
      settle(1);
      check("gpio line", gpio_o, 32'h0);
      wr(ra(`VIU_OFF_MASK0), 32'h4);
      settle(1);
      check("gpio line", gpio_o, 32'h1);
      wr(ra(`VIU_OFF_EDGE0), 32'h4);
      settle(1);
      check("gpio line", gpio_o, 32'h0);
      @(posedge clk_i);
      pin2[1] <= 1'b1;
      settle(6);
      rd(ra(`VIU_OFF_EDGE2), 32'h0);
      pin2[1] <= 1'b0;
      waitg();
      rd(ra(`VIU_OFF_EDGE2), 32'h2);
      $display("test gpio edges done");
      settle(1);
      test_done();
   end
endmodule
